// *** core/cmpc_channel.sv ***
// module: one comparator channel with synchroniser, edge detect and sticky edge flags
module cmpc_channel (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // analog result and control
   input wire logic raw,
   input wire logic on,
   input wire logic clr_rise,
   input wire logic clr_fall,
   // state and events
   output logic result,
   output logic rise_flag,
   output logic fall_flag,
   output logic rise_evt,
   output logic fall_evt
);
   logic sync_q;
   logic prev_q;

   // the raw output is asynchronous to the clock
   cmpc_sync #(.WIDTH(1)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(raw),
      .q(sync_q)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= 1'b0;
      else
         prev_q <= sync_q;
   end

   // a shut-down comparator reads low and raises no events
   assign result = sync_q & on;
   assign rise_evt = on & sync_q & ~prev_q;
   assign fall_evt = on & ~sync_q & prev_q;

   // set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rise_flag <= 1'b0;
      else if (rise_evt)
         rise_flag <= 1'b1;
      else if (clr_rise)
         rise_flag <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fall_flag <= 1'b0;
      else if (fall_evt)
         fall_flag <= 1'b1;
      else if (clr_fall)
         fall_flag <= 1'b0;
   end

   chk_rise_sets: assert property (
      @(posedge clk) disable iff (!rst_n) rise_evt |=> rise_flag)
      else $error("rising edge did not set rise flag");
   chk_fall_sets: assert property (
      @(posedge clk) disable iff (!rst_n) fall_evt |=> fall_flag)
      else $error("falling edge did not set fall flag");
   chk_flag_sticky: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rise_flag && !clr_rise) or (fall_flag && !clr_fall) |=>
      (rise_flag || !$past(rise_flag) || $past(clr_rise)) &&
      (fall_flag || !$past(fall_flag) || $past(clr_fall)))
      else $error("edge flag dropped without clear");
   chk_off_quiet: assert property (
      @(posedge clk) disable iff (!rst_n)
      !on |-> !result && !rise_evt && !fall_evt)
      else $error("disabled comparator shows output or events");
   chk_sync_lag: assert property (
      @(posedge clk) disable iff (!rst_n)
      rise_evt |-> $past(raw, 2) && !$past(raw, 3))
      else $error("rising event not two cycles after raw edge");
endmodule

// *** core/cmpc_pkg.sv ***
// package: register map, field layouts and constants of the comparator control block
package cmpc_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0] CMPC_IDX_CTRL_A = 10'h000;
   localparam logic [9:0] CMPC_IDX_CTRL_B = 10'h001;
   localparam logic [9:0] CMPC_IDX_STAT = 10'h002;
   localparam logic [9:0] CMPC_IDX_MASK = 10'h003;
   localparam logic [9:0] CMPC_IDX_PINCFG = 10'h004;
   localparam logic [9:0] CMPC_IDX_PRIO = 10'h0f6;

   // reset values
   localparam logic [7:0] CMPC_CTRL_RST = 8'h00;
   localparam logic [7:0] CMPC_PRIO_RST = 8'h00;
   localparam logic [3:0] CMPC_EVT_RST = 4'h0;
   localparam logic [4:0] CMPC_PINCFG_RST = 5'h00;

   // hysteresis select codes and their amounts in millivolts
   localparam logic [1:0] CMPC_HYST_OFF = 2'h0;
   localparam logic [1:0] CMPC_HYST_2MV = 2'h1;
   localparam logic [1:0] CMPC_HYST_4MV = 2'h2;
   localparam logic [1:0] CMPC_HYST_10MV = 2'h3;
   localparam logic [3:0] CMPC_MV_OFF = 4'h0;
   localparam logic [3:0] CMPC_MV_2 = 4'h2;
   localparam logic [3:0] CMPC_MV_4 = 4'h4;
   localparam logic [3:0] CMPC_MV_10 = 4'ha;

   // comparator control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic on;
      logic result;
      logic rise_flag;
      logic fall_flag;
      logic [1:0] pos_hyst_sel;
      logic [1:0] neg_hyst_sel;
   } cmpc_ctrl_t;

   // priority register layout, bit 7 down to bit 0
   typedef struct packed {
      logic cmp_b_rise_priority;
      logic cmp_b_fall_priority;
      logic cmp_a_rise_priority;
      logic cmp_a_fall_priority;
      logic [3:0] other;
   } cmpc_prio_t;

   // event bits of status and mask registers
   typedef struct packed {
      logic b_fall;
      logic b_rise;
      logic a_fall;
      logic a_rise;
   } cmpc_evt_t;

   // pin routing and reset source configuration
   typedef struct packed {
      logic rst_src_a;
      logic od_b;
      logic route_b;
      logic od_a;
      logic route_a;
   } cmpc_pincfg_t;

   // drive to one analog comparator stage
   typedef struct packed {
      logic on;
      logic [1:0] pos_hyst_sel;
      logic [1:0] neg_hyst_sel;
      logic [3:0] pos_mv;
      logic [3:0] neg_mv;
   } cmpc_analog_t;

endpackage

// *** core/cmpc_sync.sv ***
// module: two flip-flop synchroniser for asynchronous levels
module cmpc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** core/cmpc_top.sv ***
// module: comparator control block with APB registers, pin drive and interrupts
//
// How it works
// - enable bit turns each comparator on/off
// - disabled comparator: pin low, no new events; pending status still drives IRQ
// - read-only result bit shows comparator output
// - events on rising and falling output edges
// - rising edge sets rise flag
// - falling edge sets fall flag
// - flags sticky until software writes zero
// - positive hysteresis decode off/2/4/10 mV
// - negative hysteresis decode off/2/4/10 mV
// - first comparator may request system reset
// - second comparator never requests reset
// - second comparator behaves like first, own register
// - routed pin selectable open-drain or push-pull
module cmpc_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // analog comparator results, asynchronous
   input wire logic CMP_A_RAW,
   input wire logic CMP_B_RAW,
   // analog stage drive
   output cmpc_pkg::cmpc_analog_t CMP_A_ANALOG,
   output cmpc_pkg::cmpc_analog_t CMP_B_ANALOG,
   // port pins
   output logic CMP_A_PIN_O,
   output logic CMP_A_PIN_OE,
   output logic CMP_B_PIN_O,
   output logic CMP_B_PIN_OE,
   // reset request and interrupts
   output logic CMP_RESET_REQ,
   output logic IRQ,
   output logic IRQ_HI,
   output logic IRQ_LO
);
   import cmpc_pkg::*;

   logic rst_meta_q;
   logic rst_n;
   cmpc_ctrl_t ctrl_a_q;
   cmpc_ctrl_t ctrl_b_q;
   cmpc_prio_t prio_q;
   cmpc_evt_t stat_q;
   cmpc_evt_t mask_q;
   cmpc_evt_t evt;
   cmpc_pincfg_t pincfg_q;
   cmpc_ctrl_t wr_ctrl;
   logic [9:0] idx;
   logic mapped;
   logic wr;
   logic wr_a;
   logic wr_b;
   logic res_a;
   logic res_b;
   logic rise_a;
   logic fall_a;
   logic rise_b;
   logic fall_b;
   logic rf_a_q;
   logic ff_a_q;
   logic rf_b_q;
   logic ff_b_q;
   logic [31:0] rd_data;

   // decodes a hysteresis select into millivolts
   function automatic logic [3:0] hyst_mv(input logic [1:0] sel);
      case (sel)
         CMPC_HYST_OFF: hyst_mv = CMPC_MV_OFF;
         CMPC_HYST_2MV: hyst_mv = CMPC_MV_2;
         CMPC_HYST_4MV: hyst_mv = CMPC_MV_4;
         CMPC_HYST_10MV: hyst_mv = CMPC_MV_10;
         default: hyst_mv = CMPC_MV_OFF;
      endcase
   endfunction

   // builds the read view of a control register with live state
   function automatic logic [7:0] ctrl_view(input cmpc_ctrl_t c, input logic res,
                                           input logic rf, input logic ff);
      cmpc_ctrl_t v;
      v = c;
      v.result = res;
      v.rise_flag = rf;
      v.fall_flag = ff;
      ctrl_view = v;
   endfunction

   // reset release through two flip-flops
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // apb decode; zero wait states, so pready is always high
   assign idx = PADDR[11:2];
   assign mapped = (idx == CMPC_IDX_CTRL_A) || (idx == CMPC_IDX_CTRL_B) ||
                   (idx == CMPC_IDX_STAT) || (idx == CMPC_IDX_MASK) ||
                   (idx == CMPC_IDX_PINCFG) || (idx == CMPC_IDX_PRIO);
   assign wr = PSEL & PENABLE & PWRITE & mapped;
   assign wr_a = wr && (idx == CMPC_IDX_CTRL_A);
   assign wr_b = wr && (idx == CMPC_IDX_CTRL_B);
   assign wr_ctrl = cmpc_ctrl_t'(PWDATA[7:0]);
   assign PREADY = 1'b1;

   // writable fields of the control registers; result and flags live elsewhere
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_a_q <= cmpc_ctrl_t'(CMPC_CTRL_RST);
      else if (wr_a)
      begin
         ctrl_a_q.on <= wr_ctrl.on;
         ctrl_a_q.pos_hyst_sel <= wr_ctrl.pos_hyst_sel;
         ctrl_a_q.neg_hyst_sel <= wr_ctrl.neg_hyst_sel;
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_b_q <= cmpc_ctrl_t'(CMPC_CTRL_RST);
      else if (wr_b)
      begin
         ctrl_b_q.on <= wr_ctrl.on;
         ctrl_b_q.pos_hyst_sel <= wr_ctrl.pos_hyst_sel;
         ctrl_b_q.neg_hyst_sel <= wr_ctrl.neg_hyst_sel;
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         prio_q <= cmpc_prio_t'(CMPC_PRIO_RST);
      else if (wr && (idx == CMPC_IDX_PRIO))
         prio_q <= cmpc_prio_t'(PWDATA[7:0]);
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         mask_q <= cmpc_evt_t'(CMPC_EVT_RST);
      else if (wr && (idx == CMPC_IDX_MASK))
         mask_q <= cmpc_evt_t'(PWDATA[3:0]);
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         pincfg_q <= cmpc_pincfg_t'(CMPC_PINCFG_RST);
      else if (wr && (idx == CMPC_IDX_PINCFG))
         pincfg_q <= cmpc_pincfg_t'(PWDATA[4:0]);
   end

   // flags clear only where software writes a zero
   cmpc_channel u_cmp_a (
      .clk(CLK),
      .rst_n(rst_n),
      .raw(CMP_A_RAW),
      .on(ctrl_a_q.on),
      .clr_rise(wr_a && !wr_ctrl.rise_flag),
      .clr_fall(wr_a && !wr_ctrl.fall_flag),
      .result(res_a),
      .rise_flag(rf_a_q),
      .fall_flag(ff_a_q),
      .rise_evt(rise_a),
      .fall_evt(fall_a)
   );

   // same channel logic as the first, on its own register
   cmpc_channel u_cmp_b (
      .clk(CLK),
      .rst_n(rst_n),
      .raw(CMP_B_RAW),
      .on(ctrl_b_q.on),
      .clr_rise(wr_b && !wr_ctrl.rise_flag),
      .clr_fall(wr_b && !wr_ctrl.fall_flag),
      .result(res_b),
      .rise_flag(rf_b_q),
      .fall_flag(ff_b_q),
      .rise_evt(rise_b),
      .fall_evt(fall_b)
   );

   // sticky status, write one to clear, an event in the same cycle wins
   assign evt = '{b_fall: fall_b, b_rise: rise_b, a_fall: fall_a, a_rise: rise_a};
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         stat_q <= cmpc_evt_t'(CMPC_EVT_RST);
      else if (wr && (idx == CMPC_IDX_STAT))
         stat_q <= evt | (stat_q & ~cmpc_evt_t'(PWDATA[3:0]));
      else
         stat_q <= evt | stat_q;
   end
   assign IRQ = |(stat_q & mask_q);

   // priority split of edge flags; disabled channels are suspended
   assign IRQ_HI = ctrl_a_q.on & ((rf_a_q & prio_q.cmp_a_rise_priority) |
                                  (ff_a_q & prio_q.cmp_a_fall_priority)) |
                   ctrl_b_q.on & ((rf_b_q & prio_q.cmp_b_rise_priority) |
                                  (ff_b_q & prio_q.cmp_b_fall_priority));
   assign IRQ_LO = ctrl_a_q.on & ((rf_a_q & ~prio_q.cmp_a_rise_priority) |
                                  (ff_a_q & ~prio_q.cmp_a_fall_priority)) |
                   ctrl_b_q.on & ((rf_b_q & ~prio_q.cmp_b_rise_priority) |
                                  (ff_b_q & ~prio_q.cmp_b_fall_priority));

   // analog stage drive; software must wait out settling after enabling
   always_comb
   begin
      CMP_A_ANALOG.on = ctrl_a_q.on;
      CMP_A_ANALOG.pos_hyst_sel = ctrl_a_q.pos_hyst_sel;
      CMP_A_ANALOG.neg_hyst_sel = ctrl_a_q.neg_hyst_sel;
      CMP_A_ANALOG.pos_mv = hyst_mv(ctrl_a_q.pos_hyst_sel);
      CMP_A_ANALOG.neg_mv = hyst_mv(ctrl_a_q.neg_hyst_sel);
      CMP_B_ANALOG.on = ctrl_b_q.on;
      CMP_B_ANALOG.pos_hyst_sel = ctrl_b_q.pos_hyst_sel;
      CMP_B_ANALOG.neg_hyst_sel = ctrl_b_q.neg_hyst_sel;
      CMP_B_ANALOG.pos_mv = hyst_mv(ctrl_b_q.pos_hyst_sel);
      CMP_B_ANALOG.neg_mv = hyst_mv(ctrl_b_q.neg_hyst_sel);
   end

   // open drain only pulls low, so the high level comes from the pull-up
   assign CMP_A_PIN_O = pincfg_q.od_a ? 1'b0 : res_a;
   assign CMP_A_PIN_OE = pincfg_q.route_a & (~pincfg_q.od_a | ~res_a);
   assign CMP_B_PIN_O = pincfg_q.od_b ? 1'b0 : res_b;
   assign CMP_B_PIN_OE = pincfg_q.route_b & (~pincfg_q.od_b | ~res_b);

   // only the first comparator can reset, when enabled and its output is low
   assign CMP_RESET_REQ = pincfg_q.rst_src_a & ctrl_a_q.on & ~res_a;

   // read mux
   always_comb
   begin
      rd_data = '0;
      case (idx)
         CMPC_IDX_CTRL_A: rd_data[7:0] = ctrl_view(ctrl_a_q, res_a, rf_a_q, ff_a_q);
         CMPC_IDX_CTRL_B: rd_data[7:0] = ctrl_view(ctrl_b_q, res_b, rf_b_q, ff_b_q);
         CMPC_IDX_STAT: rd_data[3:0] = stat_q;
         CMPC_IDX_MASK: rd_data[3:0] = mask_q;
         CMPC_IDX_PINCFG: rd_data[4:0] = pincfg_q;
         CMPC_IDX_PRIO: rd_data[7:0] = prio_q;
         default: rd_data = '0;
      endcase
   end

   // read data and error are captured in the setup cycle
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end
      else if (PSEL && !PENABLE)
      begin
         PRDATA <= PWRITE ? '0 : rd_data;
         PSLVERR <= ~mapped;
      end
   end

   chk_enable_write: assert property (
      @(posedge CLK) disable iff (!rst_n)
      wr_a |=> CMP_A_ANALOG.on == $past(PWDATA[7]))
      else $error("enable bit did not follow write");
   chk_hyst_pos: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CMP_A_ANALOG.pos_hyst_sel == CMPC_HYST_4MV |-> CMP_A_ANALOG.pos_mv == CMPC_MV_4)
      else $error("positive hysteresis decode wrong");
   chk_hyst_neg: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CMP_B_ANALOG.neg_hyst_sel == CMPC_HYST_10MV |-> CMP_B_ANALOG.neg_mv == CMPC_MV_10)
      else $error("negative hysteresis decode wrong");
   chk_reset_src: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CMP_RESET_REQ |-> pincfg_q.rst_src_a && ctrl_a_q.on && !$past(CMP_A_RAW, 2))
      else $error("reset request without first comparator cause");
   chk_od_release: assert property (
      @(posedge CLK) disable iff (!rst_n)
      pincfg_q.od_a && res_a |-> !CMP_A_PIN_OE)
      else $error("open drain pin driven while output high");
   chk_prio_high: assert property (
      @(posedge CLK) disable iff (!rst_n)
      ctrl_a_q.on && rf_a_q && prio_q.cmp_a_rise_priority |-> IRQ_HI)
      else $error("high priority edge not on high request");
   chk_stat_irq: assert property (
      @(posedge CLK) disable iff (!rst_n)
      rise_a && mask_q.a_rise |=> IRQ || !mask_q.a_rise)
      else $error("masked-in edge did not raise interrupt");
   chk_flag_edge: assert property (
      @(posedge CLK) disable iff (!rst_n)
      fall_b |=> ff_b_q)
      else $error("edge lost against clear");
endmodule

// *** dv/cmpc_front_model.sv ***
// partner: behavioural analog comparator front end with an optional output lag
module cmpc_front_model #(
   parameter int LAG = 0
) (
   // clock
   input wire logic clk,
   // input voltages in millivolts
   input wire logic [15:0] noninv_mv,
   input wire logic [15:0] inv_mv,
   // comparator result
   output logic raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pipe_q;
   // a slow stage lets the result trail the inputs by several cycles
   always_ff @(posedge clk)
   begin
      pipe_q <= {pipe_q[6:0], noninv_mv > inv_mv};
   end
   // equal inputs give a low result: only strictly above counts
   assign raw = (LAG == 0) ? (noninv_mv > inv_mv) : pipe_q[(LAG == 0) ? 0 : LAG - 1];
endmodule

// *** dv/testbench.sv ***
// testbench: registers, edge flags, pins, priorities and reset source
`define CHK(g, e, m) \
   samples_checked++; \
   if ((g) !== (e)) \
   begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t %s", $time, m); \
   end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import cmpc_pkg::*;
   localparam logic [11:0] A_CA = {CMPC_IDX_CTRL_A, 2'b00};
   localparam logic [11:0] A_CB = {CMPC_IDX_CTRL_B, 2'b00};
   localparam logic [11:0] A_ST = {CMPC_IDX_STAT, 2'b00};
   localparam logic [11:0] A_MK = {CMPC_IDX_MASK, 2'b00};
   localparam logic [11:0] A_PC = {CMPC_IDX_PINCFG, 2'b00};
   localparam logic [11:0] A_PR = {CMPC_IDX_PRIO, 2'b00};
   localparam logic [15:0] REF_MV = 16'h0032;
   localparam logic [15:0] LO_MV = 16'h0028;
   localparam logic [15:0] HI_MV = 16'h003c;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic raw_a, raw_b, pin_a_o, pin_a_oe, pin_b_o, pin_b_oe, rst_req, irq, irq_hi, irq_lo;
   cmpc_analog_t ana_a, ana_b;
   logic [15:0] pa, pb;
   logic [3:0] mvt [4] = '{4'h0, 4'h2, 4'h4, 4'ha};

   cmpc_top dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CMP_A_RAW(raw_a), .CMP_B_RAW(raw_b), .CMP_A_ANALOG(ana_a),
      .CMP_B_ANALOG(ana_b), .CMP_A_PIN_O(pin_a_o), .CMP_A_PIN_OE(pin_a_oe),
      .CMP_B_PIN_O(pin_b_o), .CMP_B_PIN_OE(pin_b_oe), .CMP_RESET_REQ(rst_req),
      .IRQ(irq), .IRQ_HI(irq_hi), .IRQ_LO(irq_lo));
   cmpc_front_model #(.LAG(0)) front_a (.clk(clk), .noninv_mv(pa), .inv_mv(REF_MV), .raw(raw_a));
   cmpc_front_model #(.LAG(3)) front_b (.clk(clk), .noninv_mv(pb), .inv_mv(REF_MV), .raw(raw_b));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one apb transfer; the request is held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // enable, then sit out the settling time before trusting result or flags
   task automatic en(input logic [11:0] a, input logic [31:0] d);
      wr(a, d);
      repeat (4000) @(posedge clk);
   endtask

   task automatic lvl(input int ch, input logic [15:0] mv);
      @(posedge clk);
      if (ch == 0)
         pa <= mv;
      else
         pb <= mv;
      repeat (12) @(posedge clk);
   endtask

   task automatic t_reset_vals();
      logic [11:0] al [6] = '{A_CA, A_CB, A_ST, A_MK, A_PC, A_PR};
      foreach (al[i])
      begin
         rd(al[i]);
         `CHK(rdv, 32'h0, "reset value")
         `CHK(rerr, 1'b0, "error on mapped")
      end
      rd(12'h100);
      `CHK({rerr, rdv}, {1'b1, 32'h0}, "unmapped read")
      wr(A_CA, 32'h40);
      rd(A_CA);
      `CHK(rdv[7:0], 8'h00, "result bit writable")
   endtask

   task automatic t_hyst();
      cmpc_analog_t an;
      logic [1:0] c;
      for (int ch = 0; ch < 2; ch++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            c = i[1:0];
            wr(ch ? A_CB : A_CA, {24'h0, 4'h8, c, ~c});
            @(negedge clk);
            an = ch ? ana_b : ana_a;
            `CHK(an.on, 1'b1, "stage off")
            `CHK(an.pos_hyst_sel, c, "pos select")
            `CHK(an.pos_mv, mvt[i], "pos amount")
            `CHK(an.neg_hyst_sel, ~c, "neg select")
            `CHK(an.neg_mv, mvt[3 - i], "neg amount")
         end
         wr(ch ? A_CB : A_CA, 32'h0);
         @(negedge clk);
         an = ch ? ana_b : ana_a;
         `CHK(an.on, 1'b0, "stage not off")
      end
   endtask

   task automatic t_edges(input int ch);
      logic [11:0] base;
      logic [3:0] sb;
      base = ch ? A_CB : A_CA;
      sb = 4'h3 << (2 * ch);
      lvl(ch, LO_MV);
      en(base, 32'h80);
      wr(A_ST, 32'hf);
      wr(A_MK, {28'h0, sb});
      lvl(ch, HI_MV);
      rd(base);
      `CHK(rdv[7:4], 4'b1110, "rise not flagged")
      @(negedge clk);
      `CHK(irq, 1'b1, "irq not raised")
      lvl(ch, REF_MV);
      rd(base);
      `CHK(rdv[7:4], 4'b1011, "fall not flagged")
      wr(base, 32'hb0);
      rd(base);
      `CHK(rdv[7:4], 4'b1011, "flags lost on one")
      wr(base, 32'h80);
      rd(base);
      `CHK(rdv[7:4], 4'b1000, "flags not cleared")
      rd(A_ST);
      `CHK(rdv[3:0], sb, "status bits")
      wr(A_MK, 32'h0);
      @(negedge clk);
      `CHK(irq, 1'b0, "masked irq")
      wr(A_ST, {28'h0, sb});
      rd(A_ST);
      `CHK(rdv[3:0], 4'h0, "status not cleared")
      wr(base, 32'h0);
   endtask

   task automatic t_pins();
      lvl(0, HI_MV);
      wr(A_PC, 32'h1);
      en(A_CA, 32'h80);
      @(negedge clk);
      `CHK({pin_a_o, pin_a_oe}, 2'b11, "push-pull high")
      wr(A_PC, 32'h3);
      @(negedge clk);
      `CHK({pin_a_o, pin_a_oe}, 2'b00, "open-drain released")
      lvl(0, LO_MV);
      @(negedge clk);
      `CHK({pin_a_o, pin_a_oe}, 2'b01, "open-drain low")
      wr(A_PC, 32'h11);
      @(negedge clk);
      `CHK(rst_req, 1'b1, "no reset request")
      wr(A_CA, 32'h0);
      wr(A_ST, 32'hf);
      lvl(0, HI_MV);
      lvl(0, LO_MV);
      lvl(0, HI_MV);
      @(negedge clk);
      `CHK({pin_a_o, rst_req}, 2'b00, "disabled pin or request")
      rd(A_CA);
      `CHK(rdv[7:0], 8'h00, "disabled flags")
      rd(A_ST);
      `CHK(rdv[3:0], 4'h0, "disabled status")
      lvl(1, LO_MV);
      wr(A_CA, 32'h80);
      en(A_CB, 32'h80);
      wr(A_PC, 32'h1c);
      @(negedge clk);
      `CHK(rst_req, 1'b0, "second requests reset")
      `CHK({pin_b_o, pin_b_oe}, 2'b01, "open-drain b low")
      wr(A_CA, 32'h0);
      wr(A_CB, 32'h0);
      wr(A_PC, 32'h0);
   endtask

   task automatic t_prio();
      lvl(0, LO_MV);
      en(A_CA, 32'h80);
      lvl(0, HI_MV);
      wr(A_PR, 32'h2f);
      @(negedge clk);
      `CHK({irq_hi, irq_lo}, 2'b10, "rise high priority")
      rd(A_PR);
      `CHK(rdv, 32'h2f, "priority readback")
      wr(A_PR, 32'h10);
      @(negedge clk);
      `CHK({irq_hi, irq_lo}, 2'b01, "rise low priority")
      wr(A_CA, 32'h30);
      @(negedge clk);
      `CHK({irq_hi, irq_lo}, 2'b00, "disabled priority irq")
      rd(A_CA);
      `CHK(rdv[7:0], 8'h20, "flag lost on disable")
   endtask

   initial
   begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pa = 16'h0;
      pb = 16'h0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset_vals();
      t_hyst();
      t_edges(0);
      t_edges(1);
      t_pins();
      t_prio();
      tally_and_finish();
   end

   // the scenarios need about 20000 cycles; three times that means a hang
   initial
   begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
